// File: omcs_filt_if.sv
`timescale 1ns/1ps
// ==========================================================
// carrier between the sequencer and the no-light filter
interface omcs_filt_if;
  logic raw_dark;  // unfiltered no-light level
  logic dark;      // filtered, registered indicator
  modport ctrl (output raw_dark, input dark);
  modport filt (input raw_dark, output dark);
endinterface

// File: omcs_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host board model: request pin, slow id clock, pulled-up data line
module omcs_host_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_req,          // bench wants the laser dark
  input wire logic i_host_sda_low, // host pulls the data line low
  input wire logic i_dev_oe,       // module drives the data line
  input wire logic i_dev_out,      // module's data value
  output logic o_laser_off_req,
  output logic o_scl,
  output logic o_sda
);
  logic [5:0] div_q;
  logic [5:0] div_d;
  logic scl_q;
  logic scl_d;
  // the bench decides how long the request stays high
  assign o_laser_off_req = i_req;
  // open drain with pull-up: high unless a party pulls it low
  assign o_sda = ~((i_dev_oe & ~i_dev_out) | i_host_sda_low);
  assign o_scl = scl_q;
  // ==========================================================
  // id clock: half period of 50 cycles keeps it at 100 kHz
  always_comb
  begin
    div_d = (div_q == 6'h31) ? 6'h00 : div_q + 6'h01;
    scl_d = (div_q == 6'h31) ? ~scl_q : scl_q;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      div_q <= 6'h00;
      scl_q <= 1'b1;
    end
    else
    begin
      div_q <= div_d;
      scl_q <= scl_d;
    end
  end
endmodule

// File: omcs_no_light_filter.sv
`timescale 1ns/1ps
// ==========================================================
// debounce for the no-light indicator: changes only after the raw level
// has held steady, which keeps fibre flicker off the host pin
module omcs_no_light_filter #(
  parameter int unsigned FILT_CYC = omcs_pkg::NO_LIGHT_FILT_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  omcs_filt_if.filt f
);
  localparam int W = $clog2(FILT_CYC + 1);
  logic [W-1:0] cnt_q;  // steady cycles seen
  logic [W-1:0] cnt_d;
  logic dark_q;         // indicator, dark after reset until light seen
  logic dark_d;

  // ==========================================================
  // next values
  always_comb
  begin
    cnt_d = cnt_q;
    dark_d = dark_q;
    if (f.raw_dark == dark_q)
    begin
      cnt_d = '0;  // level agrees, nothing pending
    end
    else if (cnt_q == W'(FILT_CYC - 1))
    begin
      dark_d = f.raw_dark;
      cnt_d = '0;
    end
    else
    begin
      cnt_d = cnt_q + W'(1);
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cnt_q <= '0;
      dark_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      dark_q <= dark_d;
    end
  end

  assign f.dark = dark_q;
endmodule

// File: omcs_pkg.sv
package omcs_pkg;
  // ==========================================================
  // clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  // ==========================================================
  // times as given, in their own units
  localparam int unsigned LASER_OFF_MAX_US = 10;      // longest, off after request
  localparam int unsigned LASER_ON_MAX_MS = 1;        // longest, on after release
  localparam int unsigned INIT_MAX_MS = 300;          // longest, init window
  localparam int unsigned FAULT_FLAG_MAX_US = 100;    // longest, fault to flag
  localparam int unsigned CLEAR_HOLD_MIN_US = 10;     // least, disable hold to clear
  localparam int unsigned NO_LIGHT_MAX_US = 100;      // longest, indicator change
  localparam int unsigned POR_HOLD_MIN_MS = 140;      // least, internal reset hold
  localparam int unsigned ID_CLK_MAX_KHZ = 100;       // host limit on id clock
  // ==========================================================
  // cycle counts: least times round up, longest round down
  localparam int unsigned LASER_OFF_CYC = (LASER_OFF_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned FAULT_FLAG_CYC = (FAULT_FLAG_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned NO_LIGHT_CYC = (NO_LIGHT_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_HOLD_CYC =
    (CLEAR_HOLD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_HOLD_CYC =
    (POR_HOLD_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_MAX_CYC = (INIT_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned LASER_ON_CYC = (LASER_ON_MAX_MS * 1000000) / CLK_PERIOD_NS;
  // ==========================================================
  // filter depth for the no-light detector, well inside the limit
  localparam int unsigned NO_LIGHT_FILT_CYC = 16;
  // ==========================================================
  // top-level sequencer states
  typedef enum logic [1:0] {
    OMCS_ST_INIT = 2'b00,   // internal reset hold, laser dark
    OMCS_ST_ON = 2'b01,     // laser lit
    OMCS_ST_OFF = 2'b10,    // host asked for dark
    OMCS_ST_FAULT = 2'b11   // shutdown latched
  } omcs_state_t;
endpackage

// File: omcs_top.sv
`timescale 1ns/1ps
module omcs_top #(
  parameter int unsigned POR_HOLD_CYC = omcs_pkg::POR_HOLD_CYC,
  parameter int unsigned CLEAR_HOLD_CYC = omcs_pkg::CLEAR_HOLD_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,                 // power-on reset
  input wire logic i_laser_off_req,         // host request, high = dark
  input wire logic i_laser_fault_det,       // safety circuit fault level
  input wire logic i_rx_dark,               // raw no-light from receiver
  input wire logic i_id_serial_clock,       // two-wire clock from host
  input wire logic i_id_serial_data,        // two-wire data sensed
  input wire logic i_id_mem_data_drive_low, // id memory wants data low
  output logic o_laser_enable,              // laser driver enable
  output logic o_laser_fault_flag,          // fault flag pin
  output logic o_no_light_indicator,        // no-light pin
  output logic o_presence_ground_pin,       // presence pin level
  output logic o_id_serial_data_out,        // data pin output value
  output logic o_id_serial_data_oe,         // data pin enable, open drain
  output logic o_id_mem_scl,                // clock to id memory
  output logic o_id_mem_sda                 // data to id memory
);
  localparam int PW = $clog2(POR_HOLD_CYC + 1);
  localparam int HW = $clog2(CLEAR_HOLD_CYC + 1);

  // ==========================================================
  // sequencer state
  omcs_pkg::omcs_state_t st_q;  // current state
  omcs_pkg::omcs_state_t st_d;
  logic [PW-1:0] por_q;          // init hold counter
  logic [PW-1:0] por_d;
  logic por_done;                // hold time served
  logic [HW-1:0] hold_q;         // request high-time counter in fault
  logic [HW-1:0] hold_d;
  logic en_q;                    // registered laser enable
  logic en_d;
  logic flag_q;                  // registered fault flag
  logic flag_d;

  omcs_filt_if filt_bus ();

  // hold served; the counter saturates here and never wraps
  assign por_done = (por_q == PW'(POR_HOLD_CYC - 1));

  // ==========================================================
  // next-state logic; laser enable and fault flag are each one register behind their cause,
  // far inside the 10 us and 100 us budgets at this clock
  always_comb
  begin
    st_d = st_q;
    por_d = por_q;
    hold_d = hold_q;
    // the hold counter runs in every state, so a fault cleared early
    // cannot light the laser before the supervisory time is served
    if (!por_done)
    begin
      por_d = por_q + PW'(1);
    end
    unique case (st_q)
      omcs_pkg::OMCS_ST_INIT:
      begin
        // hold dark until the supervisory time is served
        if (por_done)
        begin
          st_d = i_laser_off_req ? omcs_pkg::OMCS_ST_OFF : omcs_pkg::OMCS_ST_ON;
        end
        if (i_laser_fault_det)
        begin
          st_d = omcs_pkg::OMCS_ST_FAULT;
        end
      end
      omcs_pkg::OMCS_ST_ON:
      begin
        if (i_laser_fault_det)
        begin
          st_d = omcs_pkg::OMCS_ST_FAULT;
        end
        else if (i_laser_off_req)
        begin
          st_d = omcs_pkg::OMCS_ST_OFF;
        end
      end
      omcs_pkg::OMCS_ST_OFF:
      begin
        if (i_laser_fault_det)
        begin
          st_d = omcs_pkg::OMCS_ST_FAULT;
        end
        else if (!i_laser_off_req)
        begin
          st_d = omcs_pkg::OMCS_ST_ON;
        end
      end
      omcs_pkg::OMCS_ST_FAULT:
      begin
        // latched; only a long enough high request clears it,
        // counted while high and released on the falling edge
        if (i_laser_off_req)
        begin
          if (hold_q != HW'(CLEAR_HOLD_CYC))
          begin
            hold_d = hold_q + HW'(1);
          end
        end
        else
        begin
          if (hold_q == HW'(CLEAR_HOLD_CYC) && !i_laser_fault_det)
          begin
            // a clear inside the hold time goes back to init, still dark
            st_d = por_done ? omcs_pkg::OMCS_ST_ON : omcs_pkg::OMCS_ST_INIT;
          end
          hold_d = '0;
        end
      end
    endcase
    if (st_d != omcs_pkg::OMCS_ST_FAULT)
    begin
      hold_d = '0;
    end
  end

  // output next values; laser only in the lit state and never with a fault
  always_comb
  begin
    en_d = (st_d == omcs_pkg::OMCS_ST_ON) && !i_laser_off_req;
    flag_d = (st_d == omcs_pkg::OMCS_ST_FAULT);
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q <= omcs_pkg::OMCS_ST_INIT;
      por_q <= '0;
      hold_q <= '0;
      en_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      por_q <= por_d;
      hold_q <= hold_d;
      en_q <= en_d;
      flag_q <= flag_d;
    end
  end

  // ==========================================================
  // no-light path
  assign filt_bus.raw_dark = i_rx_dark;
  omcs_no_light_filter u_filt (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .f(filt_bus.filt)
  );

  // ==========================================================
  // pins; the id path only passes through to the identification memory,
  // the data pin is open drain and only ever pulls low
  assign o_laser_enable = en_q;
  assign o_laser_fault_flag = flag_q;
  assign o_no_light_indicator = filt_bus.dark;
  assign o_presence_ground_pin = 1'b0;
  assign o_id_mem_scl = i_id_serial_clock;
  assign o_id_mem_sda = i_id_serial_data;
  assign o_id_serial_data_out = 1'b0;
  assign o_id_serial_data_oe = i_id_mem_data_drive_low;

  // ==========================================================
  // checks
  property p_off_fast;
    @(posedge i_clk) disable iff (i_reset)
      $rose(i_laser_off_req) |-> ##1 !o_laser_enable;
  endproperty
  a_off_fast: assert property (p_off_fast) else $error("laser still on after request");

  property p_on_fast;
    @(posedge i_clk) disable iff (i_reset)
      (st_q == omcs_pkg::OMCS_ST_OFF && !i_laser_off_req && !i_laser_fault_det)
        |-> ##1 o_laser_enable;
  endproperty
  a_on_fast: assert property (p_on_fast) else $error("laser not lit after release");

  property p_flag_fast;
    @(posedge i_clk) disable iff (i_reset)
      i_laser_fault_det |-> ##1 o_laser_fault_flag;
  endproperty
  a_flag_fast: assert property (p_flag_fast) else $error("fault flag late");

  property p_flag_dark;
    @(posedge i_clk) disable iff (i_reset)
      o_laser_fault_flag |-> !o_laser_enable;
  endproperty
  a_flag_dark: assert property (p_flag_dark) else $error("laser lit during shutdown");

  property p_latch;
    @(posedge i_clk) disable iff (i_reset)
      (o_laser_fault_flag && !i_laser_off_req) |-> ##1 (o_laser_fault_flag || $past(hold_q) != 0);
  endproperty
  a_latch: assert property (p_latch) else $error("fault flag dropped without clear");

  property p_short_pulse;
    @(posedge i_clk) disable iff (i_reset)
      (st_q == omcs_pkg::OMCS_ST_FAULT && $fell(i_laser_off_req) && hold_q < HW'(CLEAR_HOLD_CYC))
        |-> ##1 o_laser_fault_flag;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse cleared fault");

  property p_init_dark;
    @(posedge i_clk) disable iff (i_reset)
      (st_q == omcs_pkg::OMCS_ST_INIT || !por_done) |-> !o_laser_enable;
  endproperty
  a_init_dark: assert property (p_init_dark) else $error("laser lit during init");

  property p_req_high_dark;
    @(posedge i_clk) disable iff (i_reset)
      i_laser_off_req [*2] |-> !o_laser_enable;
  endproperty
  a_req_high_dark: assert property (p_req_high_dark) else $error("laser lit with request high");

  property p_presence;
    @(posedge i_clk) !o_presence_ground_pin;
  endproperty
  a_presence: assert property (p_presence) else $error("presence pin not grounded");

  property p_no_light;
    @(posedge i_clk) disable iff (i_reset)
      i_rx_dark [*8] ##1 i_rx_dark [*8] |-> ##[0:2] o_no_light_indicator;
  endproperty
  a_no_light: assert property (p_no_light) else $error("no-light indicator late");

  property p_light_back;
    @(posedge i_clk) disable iff (i_reset)
      !i_rx_dark [*8] ##1 !i_rx_dark [*8] |-> ##[0:2] !o_no_light_indicator;
  endproperty
  a_light_back: assert property (p_light_back) else $error("no-light indicator stuck");

  c_fault: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_laser_fault_flag));
  c_clear: cover property (@(posedge i_clk) disable iff (i_reset) $fell(o_laser_fault_flag));
  c_lit: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_laser_enable));
  c_dark: cover property (@(posedge i_clk) disable iff (i_reset) $rose(o_no_light_indicator));
endmodule

// File: tb_optical_module_control_status.sv
`timescale 1ns/1ps
module tb_optical_module_control_status;
  logic i_clk, rst, req, host_low, fdet, dark, drv_low;
  logic off_req, scl, sda, en, flag, nl, pres, dout, oe, mscl, msda;
  int err_total;
  int checked;
  int n;
  // short hold counts keep the run brief
  localparam int POR_CYC = 20;
  localparam int CLR_CYC = 4;
  // ==========================================================
  // far side and the block itself
  omcs_host_model HOST (.i_clk(i_clk), .i_reset(rst), .i_req(req),
    .i_host_sda_low(host_low), .i_dev_oe(oe), .i_dev_out(dout),
    .o_laser_off_req(off_req), .o_scl(scl), .o_sda(sda));
  // short hold counts keep the run brief
  omcs_top #(.POR_HOLD_CYC(POR_CYC), .CLEAR_HOLD_CYC(CLR_CYC)) DUT (.i_clk(i_clk),
    .i_reset(rst), .i_laser_off_req(off_req), .i_laser_fault_det(fdet),
    .i_rx_dark(dark), .i_id_serial_clock(scl), .i_id_serial_data(sda),
    .i_id_mem_data_drive_low(drv_low), .o_laser_enable(en),
    .o_laser_fault_flag(flag), .o_no_light_indicator(nl),
    .o_presence_ground_pin(pres), .o_id_serial_data_out(dout),
    .o_id_serial_data_oe(oe), .o_id_mem_scl(mscl), .o_id_mem_sda(msda));
  // ==========================================================
  // helpers
  function automatic logic exp_en(input logic r, input logic f);
    return ~r & ~f; // laser lit only when not asked dark and no fault
  endfunction
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // inputs change 1 ns after the edge, never on it
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic final_report();
    $display("errors=%0d checks=%0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // clock and watchdog
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial
  begin
    #500000;
    err_total++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    err_total = 0;
    checked = 0;
    rst = 1'b1;
    req = 1'b0;
    host_low = 1'b0;
    fdet = 1'b0;
    dark = 1'b1;
    drv_low = 1'b0;
    void'($urandom(32'h526844EC));
    step(8);
    chk(en, 1'b0);
    chk(pres, 1'b0);
    rst = 1'b0;
    n = 0;
    while (en !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    chk(n >= POR_CYC && n <= POR_CYC + 2, 1'b1);
    // random requests and id line traffic
    for (int i = 0; i < 30; i++)
    begin
      req = 1'($urandom_range(0, 1));
      drv_low = 1'($urandom_range(0, 1));
      host_low = 1'($urandom_range(0, 1));
      step(1);
      chk(en, exp_en(req, 1'b0));
      chk(oe, drv_low);
      chk(dout, 1'b0);
      chk(msda, ~(drv_low | host_low));
      chk(mscl, scl);
    end
    req = 1'b0;
    step(2);
    // fault raises and latches the flag
    fdet = 1'b1;
    step(1);
    chk(flag, 1'b1);
    chk(en, 1'b0);
    fdet = 1'b0;
    step($urandom_range(5, 30));
    chk(flag, 1'b1);
    // too short a pulse must not clear
    req = 1'b1;
    step(CLR_CYC - 1);
    req = 1'b0;
    step(2);
    chk(flag, 1'b1);
    // fault still present at release: no clear
    fdet = 1'b1;
    req = 1'b1;
    step(6);
    req = 1'b0;
    step(2);
    chk(flag, 1'b1);
    fdet = 1'b0;
    // qualifying pulse clears, flag stands while held
    req = 1'b1;
    step(6);
    chk(flag, 1'b1);
    req = 1'b0;
    step(1);
    chk(flag, 1'b0);
    chk(en, 1'b1);
    // no-light indicator follows the receiver within its limit
    for (int i = 0; i < 4; i++)
    begin
      dark = ~dark;
      step($urandom_range(18, 40));
      chk(nl, dark);
    end
    dark = 1'b0;
    step(20);
    chk(nl, 1'b0);
    // second reset in mid-run darkens the laser again
    rst = 1'b1;
    step(1);
    chk(en, 1'b0);
    rst = 1'b0;
    // fault inside the hold, cleared by a pulse of exactly the least length:
    // the flag drops, but the laser stays dark until the hold is served
    fdet = 1'b1;
    step(1);
    chk(flag, 1'b1);
    fdet = 1'b0;
    req = 1'b1;
    step(CLR_CYC);
    req = 1'b0;
    step(1);
    chk(flag, 1'b0);
    chk(en, 1'b0);
    // edges since release so far: fault, pulse, release
    n = CLR_CYC + 2;
    while (en !== 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    chk(n >= POR_CYC && n <= POR_CYC + 2, 1'b1);
    final_report();
  end
endmodule
